/* File: cfg_readout_pkg.sv */
`default_nettype none

// ==========================================================================
// Shared constants and carriers.
package cfg_readout_pkg;
  localparam int unsigned ADDR_W_DEFAULT = 16;
  localparam int unsigned ADDR_W_MAX = 22;
  localparam logic [31:0] POLARITY_INVERT_CODE = 32'hA5A5_5A5A;
  localparam logic RESET_DATA_OE_N = 1'b1;
  localparam logic RESET_CASCADE_OUT = 1'b1;
  localparam logic RESET_DATA_OUT = 1'b0;

  typedef struct packed {
    logic shift_clk;
    logic select_n;
    logic gate;
    logic mode_low;
    logic data_in;
    logic lock_low_block;
    logic lock_first;
    logic lock_second;
  } pins_s;

  localparam pins_s PINS_RESET = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_READ,
    MODE_DONE,
    MODE_PROGRAM
  } mode_e;
endpackage

// ==========================================================================
// Two-entry buffer with valid and ready on both sides.
module bit_buffer2 #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] slot_q [2];
  logic wr_q;
  logic rd_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = slot_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      slot_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      count_q <= 2'h0;
    end else if (flush) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) begin
        wr_q <= ~wr_q;
      end
      if (pop) begin
        rd_q <= ~rd_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

`default_nettype wire

/* File: serial_config_memory_readout.sv */
`default_nettype none

module serial_config_memory_readout
  import cfg_readout_pkg::*;
#(
  parameter int unsigned ADDR_W = cfg_readout_pkg::ADDR_W_DEFAULT,
  parameter int unsigned LOW_BLOCK_BITS = 4096
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic loader_shift_clock,
  input wire logic chip_select_n,
  input wire logic reset_gate,
  input wire logic program_mode_select_low,
  input wire logic low_block_lock,
  input wire logic region_lock_first,
  input wire logic region_lock_second,
  input wire logic [31:0] polarity_bytes,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe_n,
  output logic cascade_select_out,
  output logic [ADDR_W-1:0] address_count,
  output logic readout_done,
  output logic write_refused
);
  import cfg_readout_pkg::*;

  localparam int unsigned DEPTH = 1 << ADDR_W;
  localparam logic [ADDR_W-1:0] ADDR_LAST = '1;

  // ==========================================================================
  // Pin synchroniser.
  pins_s pins_raw;
  pins_s pins_meta_q;
  pins_s pins_sync_q;
  pins_s pins_prev_q;

  assign pins_raw = '{loader_shift_clock, chip_select_n, reset_gate, program_mode_select_low,
                      data_in, low_block_lock, region_lock_first, region_lock_second};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_meta_q <= PINS_RESET;
      pins_sync_q <= PINS_RESET;
      pins_prev_q <= PINS_RESET;
    end else begin
      pins_meta_q <= pins_raw;
      pins_sync_q <= pins_meta_q;
      pins_prev_q <= pins_sync_q;
    end
  end

  // ==========================================================================
  // Control decode.
  logic invert;
  logic gate_en;
  logic gate_reset;
  logic prog_mode;
  logic shift_edge;
  logic read_enable;
  logic count_clear;

  assign invert = (polarity_bytes == POLARITY_INVERT_CODE);
  assign gate_en = pins_sync_q.gate ^ invert;
  assign gate_reset = ~gate_en;
  assign prog_mode = ~pins_sync_q.mode_low;
  assign shift_edge = pins_sync_q.shift_clk && !pins_prev_q.shift_clk;
  assign read_enable = !prog_mode && gate_en && !pins_sync_q.select_n;
  assign count_clear = !prog_mode && gate_reset;

  // ==========================================================================
  // Array and lock decode.
  logic mem_q [DEPTH];
  logic write_ok;

  function automatic logic locked(input logic [ADDR_W-1:0] a, input pins_s p);
    logic hit;
    hit = 1'b0;
    if (p.lock_low_block && (32'(a) < LOW_BLOCK_BITS)) begin
      hit = 1'b1;
    end
    if (p.lock_first && !a[ADDR_W-1] && a[ADDR_W-2]) begin
      hit = 1'b1;
    end
    if (p.lock_second && a[ADDR_W-1]) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  logic [ADDR_W-1:0] addr_q;

  assign write_ok = prog_mode && !pins_sync_q.select_n && !locked(addr_q, pins_sync_q);

  always_ff @(posedge clk) begin
    if (shift_edge && write_ok) begin
      mem_q[addr_q] <= pins_sync_q.data_in;
    end
  end

  // ==========================================================================
  // Prefetch into the buffer, so a stalled output never drops a bit.
  logic [ADDR_W-1:0] fetch_q;
  logic fetch_end_q;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_bit;
  logic buf_push;
  logic pop;
  logic done_q;

  assign buf_push = !prog_mode && !fetch_end_q && buf_in_ready;
  assign pop = shift_edge && read_enable && !done_q && buf_out_valid;

  bit_buffer2 #(
    .W(1)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .flush(count_clear || prog_mode),
    .in_valid(!prog_mode && !fetch_end_q),
    .in_ready(buf_in_ready),
    .in_data(mem_q[fetch_q]),
    .out_valid(buf_out_valid),
    .out_ready(pop),
    .out_data(buf_out_bit)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fetch_q <= '0;
      fetch_end_q <= 1'b0;
    end else if (count_clear || prog_mode) begin
      fetch_q <= '0;
      fetch_end_q <= 1'b0;
    end else if (buf_push) begin
      fetch_q <= fetch_q + 1'b1;
      fetch_end_q <= (fetch_q == ADDR_LAST);
    end
  end

  // ==========================================================================
  // Address and bit counter.
  // The counter rests on the last bit once the array is spent, so the
  // cascade output cannot wrap into a second pass without a reset, a gate reset level or a shift edge in programming mode.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_q <= '0;
      done_q <= 1'b0;
    end else if (count_clear) begin
      addr_q <= '0;
      done_q <= 1'b0;
    end else if (prog_mode && shift_edge) begin
      addr_q <= addr_q + 1'b1;
      done_q <= 1'b0;
    end else if (pop) begin
      if (addr_q == ADDR_LAST) begin
        done_q <= 1'b1;
      end else begin
        addr_q <= addr_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Pins out.
  logic drive_d;

  assign drive_d = read_enable && !done_q && buf_out_valid;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out <= RESET_DATA_OUT;
      data_oe_n <= RESET_DATA_OE_N;
      cascade_select_out <= RESET_CASCADE_OUT;
    end else begin
      data_out <= drive_d ? buf_out_bit : RESET_DATA_OUT;
      data_oe_n <= !drive_d;
      cascade_select_out <= !(done_q && gate_en && !pins_sync_q.select_n && !prog_mode);
    end
  end

  assign address_count = addr_q;
  assign readout_done = done_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_refused <= 1'b0;
    end else begin
      write_refused <= shift_edge && prog_mode && !pins_sync_q.select_n && !write_ok;
    end
  end

  // ==========================================================================
  // Checks.
  sequence s_clear_seen;
    count_clear;
  endsequence

  sequence s_out_floats;
    ##1 data_oe_n;
  endsequence

  a_clear_zeros_counter: assert property (@(posedge clk) disable iff (rst)
    s_clear_seen |=> (addr_q == '0) && !done_q)
    else $error("counter not cleared by gate reset level");

  a_reset_floats_data: assert property (@(posedge clk) disable iff (rst)
    s_clear_seen |-> s_out_floats)
    else $error("data driven during gate reset level");

  a_drive_needs_enable: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n |-> $past(read_enable))
    else $error("data driven without select and gate");

  a_standby_no_count: assert property (@(posedge clk) disable iff (rst)
    (pins_sync_q.select_n && !prog_mode && !count_clear) |=> $stable(addr_q))
    else $error("counter moved in standby");

  a_edge_advances: assert property (@(posedge clk) disable iff (rst)
    (pop && addr_q != ADDR_LAST) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("counting edge did not advance counter");

  a_end_floats: assert property (@(posedge clk) disable iff (rst)
    (done_q && !cascade_select_out) |-> data_oe_n)
    else $error("data driven after cascade handoff");

  a_cascade_low_end: assert property (@(posedge clk) disable iff (rst)
    (done_q && read_enable) |=> !cascade_select_out)
    else $error("cascade output not low at end of array");

  a_cascade_gate_off: assert property (@(posedge clk) disable iff (rst)
    (!gate_en) |=> cascade_select_out)
    else $error("cascade output low with gate off");

  a_prog_no_drive: assert property (@(posedge clk) disable iff (rst)
    prog_mode |=> data_oe_n)
    else $error("data pin driven in programming mode");

  a_lock_blocks_write: assert property (@(posedge clk) disable iff (rst)
    (shift_edge && prog_mode && !pins_sync_q.select_n && pins_sync_q.lock_low_block
     && 32'(addr_q) < LOW_BLOCK_BITS) |=> write_refused)
    else $error("write to locked low block not refused");
endmodule

`default_nettype wire

/* File: loader_master_model.sv */
`default_nettype none

// ==========================================================================
// Loading master: the only driver of shift clock, select, gate and mode.
module loader_master_model (
  input wire logic clk,
  input wire logic data_out,
  input wire logic data_oe_n,
  output logic shift_clk,
  output logic cs_n,
  output logic gate,
  output logic mode_low,
  output logic pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q = 1'b0;
  initial begin
    shift_clk = 1'b0;
    cs_n = 1'b1;
    gate = 1'b0;
    mode_low = 1'b1;
  end
  // A released line shows the inverse of its last bit, so a stale bit never passes.
  always @(posedge clk) if (!data_oe_n) last_q <= data_out;
  assign pin = data_oe_n ? ~last_q : data_out;
  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Ten cycles cover the pin synchronisers, the prefetch and a counter clear.
  task automatic set_pins(input logic c, input logic g, input logic m);
    @(negedge clk);
    cs_n = c;
    gate = g;
    mode_low = m;
    wait_clk(10);
  endtask
  task automatic pulse();
    @(negedge clk);
    shift_clk = 1'b1;
    wait_clk(4);
    shift_clk = 1'b0;
    wait_clk(4);
  endtask
endmodule

`default_nettype wire

/* File: serial_config_memory_readout_tb.sv */
`default_nettype none

// ==========================================================================
// Bench: program the array, read it back, then exercise the gate polarity.
module serial_config_memory_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cfg_readout_pkg::*;
  localparam int unsigned AW = 6;
  localparam int unsigned LB = 8;
  localparam int unsigned N = 64;
  localparam logic [N-1:0] IMG = 64'hC3A5_0F96_5AE1_3C78;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic data_in = 1'b0;
  logic low_block_lock = 1'b0;
  logic region_lock_first = 1'b0;
  logic region_lock_second = 1'b0;
  logic [31:0] polarity_bytes = 32'h0000_0000;
  logic shift_clk, cs_n, gate, mode_low, pin;
  logic data_out, data_oe_n, cascade_select_out, readout_done, write_refused;
  logic [AW-1:0] address_count;
  int failures = 0;
  int tests_run = 0;
  int refused = 0;
  int cycles = 0;

  serial_config_memory_readout #(.ADDR_W(AW), .LOW_BLOCK_BITS(LB)) u_dut (
    .clk(clk), .rst(rst), .loader_shift_clock(shift_clk), .chip_select_n(cs_n),
    .reset_gate(gate), .program_mode_select_low(mode_low), .low_block_lock(low_block_lock),
    .region_lock_first(region_lock_first), .region_lock_second(region_lock_second),
    .polarity_bytes(polarity_bytes), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .cascade_select_out(cascade_select_out),
    .address_count(address_count), .readout_done(readout_done), .write_refused(write_refused)
  );
  loader_master_model u_master (
    .clk(clk), .data_out(data_out), .data_oe_n(data_oe_n), .shift_clk(shift_clk),
    .cs_n(cs_n), .gate(gate), .mode_low(mode_low), .pin(pin)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (write_refused === 1'b1) refused++;
    if (cycles == 8000) begin
      failures++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic t_program(input logic [N-1:0] bits, input logic lock);
    int i;
    refused = 0;
    low_block_lock = lock;
    region_lock_first = lock;
    region_lock_second = lock;
    u_master.set_pins(1'b0, 1'b1, 1'b0);
    for (i = 0; i < N; i++) begin
      data_in = bits[i];
      u_master.pulse();
      check(32'(data_oe_n), 1);
    end
    check(refused, lock ? LB + N / 4 + N / 2 : 0);
  endtask

  // Locks stay as programmed during read-out, where they must have no effect.
  task automatic t_read(input logic [N-1:0] exp);
    int i;
    u_master.set_pins(1'b1, 1'b1, 1'b1);
    u_master.set_pins(1'b1, 1'b0, 1'b1);
    check(32'(address_count), 0);
    check(32'(data_oe_n), 1);
    u_master.set_pins(1'b1, 1'b1, 1'b1);
    u_master.pulse();
    check(32'(address_count), 0);
    check(32'(data_oe_n), 1);
    u_master.set_pins(1'b0, 1'b1, 1'b1);
    for (i = 0; i < N; i++) begin
      check(32'(address_count), i);
      check(32'(data_oe_n), 0);
      check(32'(pin), 32'(exp[i]));
      u_master.pulse();
    end
    check(32'(readout_done), 1);
    check(32'(data_oe_n), 1);
    check(32'(cascade_select_out), 0);
    u_master.pulse();
    check(32'(address_count), N - 1);
    u_master.set_pins(1'b1, 1'b1, 1'b1);
    check(32'(cascade_select_out), 1);
    u_master.set_pins(1'b0, 1'b1, 1'b1);
    check(32'(cascade_select_out), 0);
    u_master.set_pins(1'b0, 1'b0, 1'b1);
    check(32'(cascade_select_out), 1);
    check(32'(data_oe_n), 1);
  endtask

  task automatic t_polarity();
    polarity_bytes = POLARITY_INVERT_CODE;
    rst = 1'b1;
    u_master.set_pins(1'b0, 1'b0, 1'b1);
    rst = 1'b0;
    u_master.wait_clk(10);
    check(32'(data_oe_n), 0);
    u_master.pulse();
    check(32'(address_count), 1);
    u_master.set_pins(1'b0, 1'b1, 1'b1);
    check(32'(address_count), 0);
    check(32'(data_oe_n), 1);
  endtask

  initial begin
    repeat (10) @(negedge clk);
    rst = 1'b0;
    u_master.wait_clk(2);
    check(32'(data_oe_n), 32'(RESET_DATA_OE_N));
    check(32'(cascade_select_out), 32'(RESET_CASCADE_OUT));
    check(32'(address_count), 0);
    t_program(IMG, 1'b0);
    t_read(IMG);
    t_program(~IMG, 1'b1);
    t_read(IMG ^ 64'h0000_0000_0000_FF00);
    t_polarity();
    stop_test();
  end
endmodule

`default_nettype wire
